//--- src/nsc_top.sv
// What this block does
// - After 7Bh, each read returns error-check status.
// - Controller masks unused status bits 3 to 5.
// - Identification read is 90h then address 00h.
// - Wait 100 us after power-up; protect low.
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module nsc_top
  import nsc_pkg::*;
#(
  parameter int PWRUP_CYC = PWRUP_CYC_DEF
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic [31:0] REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic      [31:0] REG_RDATA_O,
  input  wire logic [7:0]  NAND_IO_I,
  output logic      [7:0]  NAND_IO_O,
  output logic             NAND_IO_OE_O,
  output logic             NAND_CE_N_O,
  output logic             NAND_CLE_O,
  output logic             NAND_ALE_O,
  output logic             NAND_WE_N_O,
  output logic             NAND_READ_STROBE_N_O,
  output logic             NAND_WP_N_O,
  input  wire logic        NAND_READY_I
);

  localparam int PW_W = $clog2(PWRUP_CYC + 1);

  typedef enum logic [5:0] {
    S_PWRUP  = 6'b000001,
    S_IDLE   = 6'b000010,
    S_CMD    = 6'b000100,
    S_ADDR   = 6'b001000,
    S_READ   = 6'b010000,
    S_WAITRB = 6'b100000
  } nsc_st_t;

  nsc_cyc_if cyc ();

  nsc_st_t          st_q;
  nsc_op_t          op_q;
  nsc_op_t          op_w;
  logic             rb_m_q;
  logic             rb_s_q;
  logic [PW_W-1:0]  pw_cnt_q;
  logic             pw_done_q;
  logic             cfg_wp_q;
  logic             refused_q;
  logic             edc_mode_q;
  logic             id_mode_q;
  logic [7:0]       edc_q;
  logic [7:0]       id_q [ID_BYTES];
  logic [2:0]       idx_q;
  logic [CNT_W-1:0] wb_cnt_q;
  logic             wr_ctrl;
  logic             accept;
  logic             refuse;
  logic             id_store;

  // Bus cycle engine owns the device pins other than protect and ready/busy
  nsc_cycle u_cycle (
    .clk_i   (REF_CLK_I),
    .rst_i   (SYS_RST_I),
    .cyc     (cyc.eng),
    .io_i    (NAND_IO_I),
    .ce_n_o  (NAND_CE_N_O),
    .cle_o   (NAND_CLE_O),
    .ale_o   (NAND_ALE_O),
    .we_n_o  (NAND_WE_N_O),
    .re_n_o  (NAND_READ_STROBE_N_O),
    .io_o    (NAND_IO_O),
    .io_oe_o (NAND_IO_OE_O)
  );

  // Ready/busy is a pulled-up wired-OR line from outside the clock domain
  always_ff @(posedge REF_CLK_I) begin
    rb_m_q <= NAND_READY_I;
    rb_s_q <= rb_m_q;
  end

  // Power-up recovery count; the protect pin stays low until it expires
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      pw_cnt_q    <= '0;
      pw_done_q   <= 1'b0;
      NAND_WP_N_O <= 1'b0;
    end else begin
      if (!pw_done_q) begin
        pw_cnt_q  <= pw_cnt_q + PW_W'(1);
        pw_done_q <= (pw_cnt_q == PW_W'(PWRUP_CYC - 1));
      end
      NAND_WP_N_O <= pw_done_q & cfg_wp_q;
    end
  end

  // Order decode: anything that cannot start now is refused, not queued
  always_comb begin
    wr_ctrl = REG_WR_I && (REG_ADDR_I == REG_CTRL);
    op_w    = nsc_op_t'(REG_WDATA_I[2:0]);
    accept  = 1'b0;
    if (wr_ctrl) begin
      case (op_w)
        OP_STATUS: accept = (st_q == S_IDLE);
        OP_REPOLL: accept = (st_q == S_IDLE) && edc_mode_q;
        OP_ID:     accept = (st_q == S_IDLE) && rb_s_q;
        OP_RESET:  accept = (st_q == S_IDLE) || (st_q == S_WAITRB);
        default:   accept = 1'b0;
      endcase
    end
    refuse   = wr_ctrl && !accept;
    id_store = (st_q == S_READ) && cyc.done && (op_q == OP_ID);
  end

  // Configuration and the sticky refusal flag; a new refusal beats the clear
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      cfg_wp_q  <= CFG_WP_RST;
      refused_q <= 1'b0;
    end else begin
      if (REG_WR_I && (REG_ADDR_I == REG_CFG)) begin
        cfg_wp_q <= REG_WDATA_I[CFG_WP_BIT];
      end
      if (refuse) begin
        refused_q <= 1'b1;
      end else if (REG_WR_I && (REG_ADDR_I == REG_STAT) && REG_WDATA_I[STAT_REF_BIT]) begin
        refused_q <= 1'b0;
      end
    end
  end

  // Command sequencer: one request per bus cycle, next step on its done pulse
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      st_q       <= S_PWRUP;
      op_q       <= OP_NONE;
      cyc.req    <= 1'b0;
      cyc.kind   <= CYC_CMD;
      cyc.wdata  <= 8'h00;
      idx_q      <= '0;
      wb_cnt_q   <= '0;
      edc_mode_q <= 1'b0;
      id_mode_q  <= 1'b0;
      edc_q      <= 8'h00;
    end else begin
      cyc.req <= 1'b0;
      if (accept) begin
        op_q    <= op_w;
        cyc.req <= 1'b1;
        if (op_w == OP_REPOLL) begin
          // Device is still in status mode, so no command is sent again
          cyc.kind <= CYC_READ;
          st_q     <= S_READ;
        end else begin
          cyc.kind <= CYC_CMD;
          st_q     <= S_CMD;
          unique case (op_w)
            OP_STATUS: cyc.wdata <= CMD_EDC_STATUS;
            OP_ID:     cyc.wdata <= CMD_READ_ID;
            default:   cyc.wdata <= CMD_RESET;
          endcase
        end
      end else begin
        unique case (st_q)
          S_PWRUP: begin
            if (pw_done_q) begin
              st_q <= S_IDLE;
            end
          end
          S_IDLE: begin
          end
          S_CMD: begin
            if (cyc.done) begin
              // A new command ends whichever read mode the device was in
              edc_mode_q <= (op_q == OP_STATUS);
              id_mode_q  <= (op_q == OP_ID);
              cyc.req    <= (op_q != OP_RESET);
              if (op_q == OP_STATUS) begin
                cyc.kind <= CYC_READ;
                st_q     <= S_READ;
              end else if (op_q == OP_ID) begin
                cyc.kind  <= CYC_ADDR;
                cyc.wdata <= ADDR_READ_ID;
                st_q      <= S_ADDR;
              end else begin
                wb_cnt_q <= WB_CYC;
                st_q     <= S_WAITRB;
              end
            end
          end
          S_ADDR: begin
            if (cyc.done) begin
              idx_q    <= '0;
              cyc.req  <= 1'b1;
              cyc.kind <= CYC_READ;
              st_q     <= S_READ;
            end
          end
          S_READ: begin
            if (cyc.done) begin
              if (op_q == OP_ID) begin
                if (idx_q == 3'(ID_BYTES - 1)) begin
                  st_q <= S_IDLE;
                end else begin
                  idx_q   <= idx_q + 3'd1;
                  cyc.req <= 1'b1;
                end
              end else begin
                edc_q <= cyc.rdata & EDC_KEEP_MASK;
                st_q  <= S_IDLE;
              end
            end
          end
          S_WAITRB: begin
            // Ignore ready/busy until the device has had time to pull it low
            if (wb_cnt_q != '0) begin
              wb_cnt_q <= wb_cnt_q - CNT_W'(1);
            end else if (rb_s_q) begin
              st_q <= S_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Chip select stays low for the whole sequence once power-up is over
  assign cyc.keep = (st_q != S_IDLE) && (st_q != S_PWRUP);

  // Identification bytes, stored in arrival order
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      for (int i = 0; i < ID_BYTES; i++) begin
        id_q[i] <= 8'h00;
      end
    end else if (id_store) begin
      id_q[idx_q] <= cyc.rdata;
    end
  end

  // Register read port; data stands only in the cycle after the strobe
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      REG_RDATA_O <= 32'h0000_0000;
    end else begin
      REG_RDATA_O <= 32'h0000_0000;
      if (REG_RD_I) begin
        if (REG_ADDR_I == REG_CTRL) begin
          REG_RDATA_O <= {29'h0, op_q};
        end else if (REG_ADDR_I == REG_CFG) begin
          REG_RDATA_O <= {31'h0, cfg_wp_q};
        end else if (REG_ADDR_I == REG_STAT) begin
          REG_RDATA_O[STAT_BUSY_BIT] <= (st_q != S_IDLE);
          REG_RDATA_O[STAT_PWR_BIT]  <= pw_done_q;
          REG_RDATA_O[STAT_RDY_BIT]  <= rb_s_q;
          REG_RDATA_O[STAT_REF_BIT]  <= refused_q;
          REG_RDATA_O[STAT_EDCM_BIT] <= edc_mode_q;
          REG_RDATA_O[STAT_IDM_BIT]  <= id_mode_q;
        end else if (REG_ADDR_I == REG_EDC) begin
          REG_RDATA_O <= {24'h0, edc_q};
        end
        for (int i = 0; i < ID_BYTES; i++) begin
          if (REG_ADDR_I == REG_ID0 + 8'(i) * REG_STEP) begin
            REG_RDATA_O <= {24'h0, id_q[i]};
          end
        end
      end
    end
  end

endmodule : nsc_top

`default_nettype wire

//--- src/nsc_pkg.sv
package nsc_pkg;

  // Clock and bus-cycle timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int CNT_W         = 4;
  localparam int STROBE_NS     = 40;   // Write strobe low time; the read strobe adds SYNC_STAGES cycles
  localparam int HOLD_NS       = 40;   // Strobe high time before the next cycle
  localparam int WB_NS         = 100;  // Ready/busy settle time after a command
  localparam int SYNC_STAGES   = 2;
  localparam int PWRUP_US      = 100;  // Recovery time after power-up
  localparam int PWRUP_CYC_DEF = (PWRUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] STROBE_CYC =
    CNT_W'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RD_STROBE_CYC = STROBE_CYC + CNT_W'(SYNC_STAGES);
  localparam logic [CNT_W-1:0] HOLD_CYC =
    CNT_W'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WB_CYC =
    CNT_W'((WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Device command and address bytes
  localparam logic [7:0] CMD_EDC_STATUS = 8'h7b;
  localparam logic [7:0] CMD_READ_ID    = 8'h90;
  localparam logic [7:0] ADDR_READ_ID   = 8'h00;
  localparam logic [7:0] CMD_RESET      = 8'hff;
  localparam int         ID_BYTES       = 5;
  localparam logic [7:0] EDC_KEEP_MASK  = 8'hc7; // Bits 0,1,2,6,7 carry meaning

  // Software register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG  = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_EDC  = 8'h0c;
  localparam logic [7:0] REG_ID0  = 8'h10;
  localparam logic [7:0] REG_STEP = 8'h04;

  // Field positions and reset values
  localparam int   CFG_WP_BIT     = 0;
  localparam int   STAT_BUSY_BIT  = 0;
  localparam int   STAT_PWR_BIT   = 1;
  localparam int   STAT_RDY_BIT   = 2;
  localparam int   STAT_REF_BIT   = 3;
  localparam int   STAT_EDCM_BIT  = 4;
  localparam int   STAT_IDM_BIT   = 5;
  localparam logic CFG_WP_RST     = 1'b0;

  typedef enum logic [2:0] {
    OP_NONE   = 3'h0,
    OP_STATUS = 3'h1,
    OP_REPOLL = 3'h2,
    OP_ID     = 3'h3,
    OP_RESET  = 3'h4
  } nsc_op_t;

  typedef enum logic [1:0] {
    CYC_CMD  = 2'h0,
    CYC_ADDR = 2'h1,
    CYC_READ = 2'h2
  } nsc_cyc_t;

endpackage : nsc_pkg

//--- src/nsc_cyc_if.sv
`timescale 1ns/1ns
`default_nettype none

interface nsc_cyc_if
  import nsc_pkg::*;
();
  logic       req;    // One-cycle start of a bus cycle
  logic       keep;   // Hold chip select low between cycles of one sequence
  nsc_cyc_t   kind;
  logic [7:0] wdata;
  logic       done;   // One-cycle end of a bus cycle
  logic [7:0] rdata;

  modport seq (output req, keep, kind, wdata, input done, rdata);
  modport eng (input req, keep, kind, wdata, output done, rdata);
endinterface : nsc_cyc_if

`default_nettype wire

//--- src/nsc_cycle.sv
`timescale 1ns/1ns
`default_nettype none

module nsc_cycle
  import nsc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  nsc_cyc_if.eng          cyc,
  input  wire logic [7:0] io_i,
  output logic            ce_n_o,
  output logic            cle_o,
  output logic            ale_o,
  output logic            we_n_o,
  output logic            re_n_o,
  output logic [7:0]      io_o,
  output logic            io_oe_o
);

  typedef enum logic [3:0] {
    E_IDLE   = 4'b0001,
    E_SETUP  = 4'b0010,
    E_STROBE = 4'b0100,
    E_HOLD   = 4'b1000
  } nsc_eng_t;

  nsc_eng_t         st_q;
  logic [CNT_W-1:0] cnt_q;
  logic             rd_q;
  logic [7:0]       io_m_q;
  logic [7:0]       io_s_q;

  // Data pins come from outside the clock domain
  always_ff @(posedge clk_i) begin
    io_m_q <= io_i;
    io_s_q <= io_m_q;
  end

  // One command, address or read cycle per request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q      <= E_IDLE;
      cnt_q     <= '0;
      rd_q      <= 1'b0;
      ce_n_o    <= 1'b1;
      cle_o     <= 1'b0;
      ale_o     <= 1'b0;
      we_n_o    <= 1'b1;
      re_n_o    <= 1'b1;
      io_o      <= 8'h00;
      io_oe_o   <= 1'b0;
      cyc.done  <= 1'b0;
      cyc.rdata <= 8'h00;
    end else begin
      cyc.done <= 1'b0;
      unique case (st_q)
        E_IDLE: begin
          ce_n_o <= ~(cyc.keep | cyc.req);
          if (cyc.req) begin
            rd_q    <= (cyc.kind == CYC_READ);
            cle_o   <= (cyc.kind == CYC_CMD);
            ale_o   <= (cyc.kind == CYC_ADDR);
            io_o    <= cyc.wdata;
            io_oe_o <= (cyc.kind != CYC_READ);
            st_q    <= E_SETUP;
          end
        end
        E_SETUP: begin
          // Read strobe falls after chip select, so the device drives data from here
          we_n_o <= rd_q;
          re_n_o <= ~rd_q;
          cnt_q  <= (rd_q ? RD_STROBE_CYC : STROBE_CYC) - CNT_W'(1);
          st_q   <= E_STROBE;
        end
        E_STROBE: begin
          if (cnt_q == '0) begin
            // Sample before the strobe rises; the two sync stages are in the low time
            if (rd_q) begin
              cyc.rdata <= io_s_q;
            end
            we_n_o <= 1'b1;
            re_n_o <= 1'b1;
            cnt_q  <= HOLD_CYC - CNT_W'(1);
            st_q   <= E_HOLD;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        E_HOLD: begin
          if (cnt_q == '0) begin
            cle_o    <= 1'b0;
            ale_o    <= 1'b0;
            io_oe_o  <= 1'b0;
            cyc.done <= 1'b1;
            st_q     <= E_IDLE;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
      endcase
    end
  end

endmodule : nsc_cycle

`default_nettype wire

//--- verif/nsc_dev_model.sv
`timescale 1ns/1ns
`default_nettype none

module nsc_dev_model #(
  parameter int         RST_TICKS = 40,
  parameter logic [7:0] ID_B [5]  = '{default: 8'h00}
) (
  input  wire logic       ce_n_i,
  input  wire logic       cle_i,
  input  wire logic       ale_i,
  input  wire logic       we_n_i,
  input  wire logic       rs_n_i,
  input  wire logic       wp_n_i,
  input  wire logic [7:0] io_i,
  input  wire logic       hold_i,
  input  wire logic [2:0] sec_i,
  output logic      [7:0] io_o,
  output logic            rb_oe_o
);
  logic [1:0] mode_q = 2'd0;
  logic [2:0] id_q   = 3'd0;
  logic       clr_q  = 1'b0;
  logic [7:0] last_q = 8'h00;
  int         busy_q = 0;

  // Bytes latched on the strobe rise; a reset during reset reloads the timer
  always @(posedge we_n_i) begin
    if (!ce_n_i && cle_i) begin
      case (io_i)
        8'h7b: mode_q = 2'd1;
        8'h90: mode_q = 2'd2;
        8'hff: begin
          mode_q = 2'd0;
          clr_q  = 1'b1;
          busy_q = RST_TICKS;
        end
        default: mode_q = 2'd0;
      endcase
    end else if (!ce_n_i && ale_i && io_i == 8'h00) begin
      id_q = 3'd0;
    end
  end

  // Identification bytes advance at the end of each read
  always @(posedge rs_n_i) begin
    if (!ce_n_i && mode_q == 2'd2 && id_q < 3'd4) id_q = id_q + 3'd1;
  end

  // Busy timer in half-cycle ticks
  always #10 begin
    if (busy_q > 0) busy_q = busy_q - 1;
  end
  assign rb_oe_o = (busy_q != 0) || hold_i;

  // Unused bits read as ones until a reset clears the register
  wire [7:0] stat_b = {wp_n_i, !rb_oe_o, clr_q ? 6'h00 : {3'b111, sec_i}};
  wire [7:0] dout = mode_q == 2'd1 ? stat_b : (mode_q == 2'd2 ? ID_B[id_q] : 8'h00);

  // Drives while both selects are low, tracking live status; else an inverted pattern
  always @(ce_n_i, rs_n_i, dout) begin
    if (!ce_n_i && !rs_n_i) begin
      io_o   = dout;
      last_q = dout;
    end else begin
      io_o = ~last_q;
    end
  end
endmodule : nsc_dev_model

`default_nettype wire

//--- verif/nsc_top_sva.sv
`timescale 1ns/1ns
`default_nettype none

module nsc_top_sva
  import nsc_pkg::*;
#(
  parameter int PWRUP_CYC = PWRUP_CYC_DEF
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        REG_RD_I,
  input  wire logic [31:0] REG_RDATA_O,
  input  wire logic [7:0]  NAND_IO_O,
  input  wire logic        NAND_IO_OE_O,
  input  wire logic        NAND_CE_N_O,
  input  wire logic        NAND_CLE_O,
  input  wire logic        NAND_ALE_O,
  input  wire logic        NAND_WE_N_O,
  input  wire logic        NAND_READ_STROBE_N_O,
  input  wire logic        NAND_WP_N_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  int pwr_q;

  // Saturating count since reset release, so it never wraps
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) pwr_q <= 0;
    else if (pwr_q < PWRUP_CYC) pwr_q <= pwr_q + 1;
  end

  chk_pwrup_quiet: assert property (pwr_q < PWRUP_CYC |-> NAND_CE_N_O && !NAND_WP_N_O)
    else $error("device touched during power-up");
  chk_latch_frame: assert property ($fell(NAND_WE_N_O) |-> !NAND_CE_N_O && (NAND_CLE_O ^ NAND_ALE_O))
    else $error("write strobe without one latch enable");
  chk_we_width: assert property ($fell(NAND_WE_N_O) |-> !NAND_WE_N_O [*2] ##1 NAND_WE_N_O)
    else $error("write strobe width wrong");
  chk_latch_hold: assert property ($rose(NAND_WE_N_O) |-> NAND_IO_OE_O && $stable(NAND_IO_O)
    && $stable(NAND_CLE_O) && $stable(NAND_ALE_O))
    else $error("bus moved at write strobe rise");
  chk_id_address: assert property ($rose(NAND_WE_N_O) && NAND_CLE_O && NAND_IO_O == CMD_READ_ID
    |-> ##[1:12] ($rose(NAND_WE_N_O) && NAND_ALE_O && NAND_IO_O == ADDR_READ_ID))
    else $error("identification address missing");
  chk_status_read: assert property ($rose(NAND_WE_N_O) && NAND_CLE_O && NAND_IO_O == CMD_EDC_STATUS
    |-> ##[1:12] $fell(NAND_READ_STROBE_N_O))
    else $error("no read after status command");
  chk_read_width: assert property ($fell(NAND_READ_STROBE_N_O)
    |-> (!NAND_READ_STROBE_N_O && !NAND_CE_N_O && !NAND_IO_OE_O) [*4] ##1 NAND_READ_STROBE_N_O)
    else $error("read strobe frame wrong");
  chk_rdata_idle: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 32'h0)
    else $error("read data outside its cycle");

  cover property ($rose(NAND_WE_N_O) && NAND_CLE_O && NAND_IO_O == CMD_EDC_STATUS);
  cover property ($rose(NAND_WE_N_O) && NAND_ALE_O && NAND_IO_O == ADDR_READ_ID);
  cover property ($rose(NAND_WE_N_O) && NAND_CLE_O && NAND_IO_O == CMD_RESET);
endmodule : nsc_top_sva

bind nsc_top nsc_top_sva #(.PWRUP_CYC(PWRUP_CYC)) u_nsc_top_sva (.REF_CLK_I, .SYS_RST_I,
  .REG_RD_I, .REG_RDATA_O, .NAND_IO_O, .NAND_IO_OE_O, .NAND_CE_N_O, .NAND_CLE_O, .NAND_ALE_O,
  .NAND_WE_N_O, .NAND_READ_STROBE_N_O, .NAND_WP_N_O);

`default_nettype wire

//--- verif/tb_nsc_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_nsc_top
  import nsc_pkg::*;
;
  localparam int         PWR       = 8;
  localparam int         RST_TICKS = 40;  // 400 ns reset busy time
  localparam logic [7:0] ID_B [5]  = '{8'h3a, 8'h61, 8'h27, 8'h4e, 8'h1f};  // Arbitrary values
  logic        clk;
  logic        rst;
  logic        wr;
  logic        rd;
  logic        hold;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [2:0]  sec;
  int          fail_count      = 0;
  int          samples_checked = 0;
  int          cyc             = 0;
  wire  [31:0] rdata_o;
  wire  [7:0]  io_o, dev_io;
  wire         io_oe, ce_n, cle, ale, we_n, rs_n, wp_n, rb_oe;
  wire  [7:0]  io_bus = io_oe ? io_o : dev_io;
  wire         ready  = rb_oe ? 1'b0 : 1'b1;  // Pulled up, wired-OR

  nsc_top #(.PWRUP_CYC(PWR)) u_nsc_top (.REF_CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata_o),
    .NAND_IO_I(io_bus), .NAND_IO_O(io_o), .NAND_IO_OE_O(io_oe), .NAND_CE_N_O(ce_n),
    .NAND_CLE_O(cle), .NAND_ALE_O(ale), .NAND_WE_N_O(we_n), .NAND_READ_STROBE_N_O(rs_n),
    .NAND_WP_N_O(wp_n), .NAND_READY_I(ready));
  nsc_dev_model #(.RST_TICKS(RST_TICKS), .ID_B(ID_B)) u_nsc_dev_model (.ce_n_i(ce_n),
    .cle_i(cle), .ale_i(ale), .we_n_i(we_n), .rs_n_i(rs_n), .wp_n_i(wp_n), .io_i(io_bus),
    .hold_i(hold), .sec_i(sec), .io_o(dev_io), .rb_oe_o(rb_oe));

  // Clock and a free cycle count for timing checks
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata_o;
  endtask : reg_rd

  task automatic op(input logic [2:0] o);
    reg_wr(REG_CTRL, {29'h0, o});
  endtask : op

  task automatic chk_stat(input int b, input logic e);
    logic [31:0] s;
    reg_rd(REG_STAT, s);
    check("status bit", {31'h0, e}, {31'h0, s[b]});
  endtask : chk_stat

  // Bounded poll, since a hung sequencer must not stall the run
  task automatic wait_idle;
    logic [31:0] s;
    s = 32'h1;
    for (int i = 0; i < 300 && s[STAT_BUSY_BIT] !== 1'b0; i++) reg_rd(REG_STAT, s);
    check("busy", 32'h0, {31'h0, s[STAT_BUSY_BIT]});
  endtask : wait_idle

  task automatic t_power;
    logic [31:0] v;
    op(3'h1);
    chk_stat(STAT_REF_BIT, 1'b1);
    chk_stat(STAT_PWR_BIT, 1'b0);
    reg_rd(REG_CFG, v);
    check("config", 32'h0, v);
    reg_rd(8'h40, v);
    check("unmapped", 32'h0, v);
    repeat (PWR) @(posedge clk);
    chk_stat(STAT_PWR_BIT, 1'b1);
    reg_wr(REG_STAT, 32'h8);
    chk_stat(STAT_REF_BIT, 1'b0);
    reg_wr(REG_CFG, 32'h1);
    repeat (2) @(posedge clk);
    #1 check("protect pin", 32'h1, {31'h0, wp_n});
    $display("t_power done");
  endtask : t_power

  task automatic t_status;
    logic [31:0] v;
    sec <= 3'b101;
    op(3'h1);
    wait_idle;
    reg_rd(REG_EDC, v);
    check("error check", 32'hc5, v);
    chk_stat(STAT_EDCM_BIT, 1'b1);
    sec <= 3'b010;
    hold <= 1'b1;
    op(3'h2);
    wait_idle;
    reg_rd(REG_EDC, v);
    check("live status", 32'h82, v);
    chk_stat(STAT_RDY_BIT, 1'b0);
    hold <= 1'b0;
    // Ready needs both sync stages before an identification start is allowed
    repeat (3) @(posedge clk);
    chk_stat(STAT_RDY_BIT, 1'b1);
    $display("t_status done");
  endtask : t_status

  task automatic t_ident;
    logic [31:0] v;
    op(3'h3);
    wait_idle;
    for (int i = 0; i < ID_BYTES; i++) begin
      reg_rd(8'(REG_ID0 + REG_STEP * i), v);
      check("ident byte", {24'h0, ID_B[i]}, v);
    end
    chk_stat(STAT_IDM_BIT, 1'b1);
    op(3'h2);
    chk_stat(STAT_REF_BIT, 1'b1);
    reg_wr(REG_STAT, 32'h8);
    hold <= 1'b1;
    repeat (4) @(posedge clk);
    op(3'h3);
    chk_stat(STAT_REF_BIT, 1'b1);
    hold <= 1'b0;
    reg_wr(REG_STAT, 32'h8);
    $display("t_ident done");
  endtask : t_ident

  task automatic t_reset;
    logic [31:0] v;
    int          t0;
    op(3'h4);
    repeat (15) @(posedge clk);
    op(3'h4);
    t0 = cyc;
    chk_stat(STAT_REF_BIT, 1'b0);
    wait_idle;
    check("reset busy", 32'h1, {31'h0, (cyc - t0) >= RST_TICKS / 2});
    reg_rd(REG_CTRL, v);
    check("last op", 32'h4, v);
    op(3'h1);
    wait_idle;
    reg_rd(REG_EDC, v);
    check("status after reset", 32'hc0, v);
    $display("t_reset done");
  endtask : t_reset

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; hold = 1'b0;
    addr = 8'h00; wdata = 32'h0; sec = 3'b000;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_power;
    t_status;
    t_ident;
    t_reset;
    finish_test;
  end

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #1000000;
    fail_count++;
    finish_test;
  end
endmodule : tb_nsc_top

`default_nettype wire
